// ---- common/apsts_hold_if.sv ----
// Carrier between the status block and its override hold timer.
// Assumes both ends run on the same master clock.
`timescale 1ns/1ps
interface apsts_hold_if;
    logic btn_level;
    logic override_en;
    logic expired;

    modport timer (input btn_level, input override_en, output expired);
    modport ctrl (output btn_level, output override_en, input expired);
endinterface : apsts_hold_if

// ---- common/apsts_pkg.sv ----
// Constants for the second power-management status register block.
// Assumes a 100 MHz master clock and a 32.768 kHz standby time base.
package apsts_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int IO_ADDR_W = 12;
    localparam logic [11:0] STS_HI_OFFSET = 12'h001;
    localparam logic [7:0] STS_HI_RESET = 8'h00;
    // Readable bits: 0, 2, 3 and 7; bit 1 and bits 4 to 6 read zero
    localparam logic [7:0] STS_HI_RD_MASK = 8'h8D;

    localparam int BIT_BUTTON = 0;
    localparam int BIT_ALARM = 2;
    localparam int BIT_OVERRIDE = 3;
    localparam int BIT_WAKE = 7;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 100_000_000;
    localparam int STBY_CLK_HZ = 32_768;
    localparam int HOLD_TIME_S = 4;
    localparam int STBY_DIV = CLK_HZ / STBY_CLK_HZ;
    localparam int HOLD_TICKS = HOLD_TIME_S * STBY_CLK_HZ;

    // ------------------------------------------------------------
    // System power state
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_WORK = 3'b001,
        ST_SLEEP = 3'b010,
        ST_OFF = 3'b100
    } apsts_state_t;

endpackage : apsts_pkg

// ---- rtl/apsts_hold_timer.sv ----
// Power-button override hold timer on a divided standby time base.
// Assumes a synchronised button level on the carrier.
`timescale 1ns/1ps
module apsts_hold_timer #(
    parameter int DIV = 3051,
    parameter int TICKS = 131072
) (
    input wire logic mclk_i,
    input wire logic reset_i,
    apsts_hold_if.timer hold
);
    localparam int DW = $clog2(DIV + 1);
    localparam int TW = $clog2(TICKS + 2);

    generate
        if (DIV < 1 || TICKS < 1) begin : g_bad
            $error("apsts_hold_timer: DIV and TICKS must be at least 1");
        end
    endgenerate

    logic [DW-1:0] div_q;
    logic tick;
    logic [TW-1:0] cnt_q;
    logic fired_q;

    assign tick = (div_q == DW'(DIV - 1));

    always_ff @(posedge mclk_i) begin
        if (reset_i || tick) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + DW'(1);
        end
    end

    // Restart from zero on release; fire once per hold
    always_ff @(posedge mclk_i) begin
        if (reset_i || !hold.btn_level || !hold.override_en) begin
            cnt_q <= '0;
            fired_q <= 1'b0;
            hold.expired <= 1'b0;
        end else begin
            hold.expired <= 1'b0;
            if (tick && !fired_q) begin
                cnt_q <= cnt_q + TW'(1);
            end
            // More than the hold time: one tick past the count
            if (!fired_q && cnt_q > TW'(TICKS)) begin
                fired_q <= 1'b1;
                hold.expired <= 1'b1;
            end
        end
    end
endmodule : apsts_hold_timer

// ---- rtl/apsts_status_hi.sv ----
// Second power-management status register with power sequencing.
// Assumes reset_i is the battery power-on reset and io strobes are one-cycle.
`timescale 1ns/1ps
module apsts_status_hi
    import apsts_pkg::*;
#(
    parameter int STBY_DIV_P = apsts_pkg::STBY_DIV,
    parameter int HOLD_TICKS_P = apsts_pkg::HOLD_TICKS
) (
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic [apsts_pkg::IO_ADDR_W-1:0] pm_block_base_i,
    input wire logic [apsts_pkg::IO_ADDR_W-1:0] io_addr_i,
    input wire logic io_wr_i,
    input wire logic io_rd_i,
    input wire logic [7:0] io_wdata_i,
    output logic [7:0] io_rdata_o,
    input wire logic button_in_i,
    input wire logic standby_present_i,
    input wire logic alarm_i,
    input wire logic wake_event_i,
    input wire logic sleep_req_i,
    input wire logic button_event_enable_i,
    input wire logic alarm_event_enable_i,
    input wire logic override_enable_i,
    input wire logic alarm_memory_enable_i,
    input wire logic wake_source_select_i,
    output logic sci_o,
    output logic wake_pulse_o,
    output logic power_on_out_n_o,
    output logic power_on_oe_o,
    output logic working_o
);
    import apsts_pkg::*;

    // ------------------------------------------------------------
    // Input conditioning
    // ------------------------------------------------------------
    logic [1:0] pin_level;
    logic btn_lvl;
    logic stby_lvl;
    logic btn_prev_q;
    logic stby_prev_q;
    logic btn_rise;
    logic stby_rise;

    apsts_sync3 #(.WIDTH(2)) u_sync (
        .mclk_i(mclk_i),
        .reset_i(reset_i),
        .async_i({standby_present_i, button_in_i}),
        .level_o(pin_level)
    );

    assign btn_lvl = pin_level[0];
    assign stby_lvl = pin_level[1];
    assign btn_rise = btn_lvl && !btn_prev_q;
    assign stby_rise = stby_lvl && !stby_prev_q;

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            btn_prev_q <= 1'b0;
            stby_prev_q <= 1'b0;
        end else begin
            btn_prev_q <= btn_lvl;
            stby_prev_q <= stby_lvl;
        end
    end

    // ------------------------------------------------------------
    // Override hold timer
    // ------------------------------------------------------------
    apsts_hold_if hold_if ();
    logic override_hit;

    assign hold_if.btn_level = btn_lvl;
    assign hold_if.override_en = override_enable_i;
    assign override_hit = hold_if.expired && override_enable_i;

    apsts_hold_timer #(.DIV(STBY_DIV_P), .TICKS(HOLD_TICKS_P)) u_hold (
        .mclk_i(mclk_i),
        .reset_i(reset_i),
        .hold(hold_if.timer)
    );

    // ------------------------------------------------------------
    // Power sequencing
    // ------------------------------------------------------------
    apsts_state_t state_q;
    logic pwr_on_q;
    logic pwr_prev_q;
    logic remember_q;
    logic mem_fire;
    logic asleep;
    logic wake_req;
    logic wake_set;

    assign asleep = (state_q != ST_WORK);
    assign mem_fire = remember_q && stby_rise;
    // Button always wakes, regardless of its event enable
    assign wake_req = (asleep && (btn_rise || wake_event_i)) || mem_fire;
    // Power-on falling edge, plus enabled wake events when selected
    assign wake_set = (asleep && pwr_on_q && !pwr_prev_q)
        || (asleep && wake_source_select_i && wake_event_i);

    // Remember an alarm seen while standby supply is missing
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            remember_q <= 1'b0;
        end else if (alarm_i && !stby_lvl && alarm_memory_enable_i) begin
            remember_q <= 1'b1;
        end else if (stby_rise) begin
            remember_q <= 1'b0;
        end
    end

    // Override wins over a simultaneous wake request
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            pwr_on_q <= 1'b0;
        end else if (override_hit) begin
            pwr_on_q <= 1'b0;
        end else if (wake_req) begin
            pwr_on_q <= 1'b1;
        end else if (sleep_req_i && !asleep) begin
            pwr_on_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            pwr_prev_q <= 1'b0;
        end else begin
            pwr_prev_q <= pwr_on_q;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            state_q <= ST_OFF;
        end else if (override_hit) begin
            state_q <= ST_OFF;
        end else begin
            unique case (state_q)
                ST_WORK: begin
                    if (sleep_req_i) begin
                        state_q <= ST_SLEEP;
                    end
                end
                ST_SLEEP, ST_OFF: begin
                    if (wake_set) begin
                        state_q <= ST_WORK;
                    end
                end
                default: begin
                    state_q <= ST_OFF;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------
    logic wr_hit;
    logic rd_hit;
    logic [7:0] clr;
    logic btn_flag_q;
    logic alarm_flag_q;
    logic ovr_flag_q;
    logic wake_flag_q;
    logic [7:0] sts_view;

    assign wr_hit = io_wr_i && (io_addr_i == pm_block_base_i + STS_HI_OFFSET);
    assign rd_hit = io_rd_i && (io_addr_i == pm_block_base_i + STS_HI_OFFSET);
    // Reserved bits are masked off, so stray ones there are harmless
    assign clr = wr_hit ? (io_wdata_i & STS_HI_RD_MASK) : 8'h00;

    // Set beats clear; override clear beats both
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            btn_flag_q <= STS_HI_RESET[BIT_BUTTON];
        end else if (override_hit) begin
            btn_flag_q <= 1'b0;
        end else if (btn_rise) begin
            btn_flag_q <= 1'b1;
        end else if (clr[BIT_BUTTON]) begin
            btn_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            alarm_flag_q <= STS_HI_RESET[BIT_ALARM];
        end else if (alarm_i) begin
            alarm_flag_q <= 1'b1;
        end else if (clr[BIT_ALARM]) begin
            alarm_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            ovr_flag_q <= STS_HI_RESET[BIT_OVERRIDE];
        end else if (override_hit) begin
            ovr_flag_q <= 1'b1;
        end else if (clr[BIT_OVERRIDE]) begin
            ovr_flag_q <= 1'b0;
        end
    end

    // Clearing only counts while power-on is driven low
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            wake_flag_q <= STS_HI_RESET[BIT_WAKE];
        end else if (wake_set) begin
            wake_flag_q <= 1'b1;
        end else if (clr[BIT_WAKE] && pwr_on_q) begin
            wake_flag_q <= 1'b0;
        end
    end

    always_comb begin
        sts_view = 8'h00;
        sts_view[BIT_BUTTON] = btn_flag_q;
        sts_view[BIT_ALARM] = alarm_flag_q;
        sts_view[BIT_OVERRIDE] = ovr_flag_q;
        sts_view[BIT_WAKE] = wake_flag_q;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            io_rdata_o <= 8'h00;
        end else if (rd_hit) begin
            io_rdata_o <= sts_view & STS_HI_RD_MASK;
        end else begin
            io_rdata_o <= 8'h00;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            sci_o <= 1'b0;
        end else begin
            sci_o <= (!asleep && button_event_enable_i && btn_flag_q)
                || (alarm_event_enable_i && alarm_flag_q);
        end
    end

    // Open-drain: drive low while on, float while off
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            power_on_out_n_o <= 1'b0;
            power_on_oe_o <= 1'b0;
            wake_pulse_o <= 1'b0;
            working_o <= 1'b0;
        end else begin
            power_on_out_n_o <= 1'b0;
            power_on_oe_o <= pwr_on_q;
            wake_pulse_o <= wake_req;
            working_o <= !asleep;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);

    a_button_sets: assert property (btn_rise && !override_hit |=> btn_flag_q)
        else $error("button press did not set flag");
    a_sci_button: assert property (!asleep && button_event_enable_i && btn_flag_q
        |=> sci_o)
        else $error("button SCI missing");
    a_button_wakes: assert property (asleep && btn_rise && !override_hit
        |=> pwr_on_q ##1 power_on_oe_o)
        else $error("button did not wake");
    a_zero_write: assert property (wr_hit && io_wdata_i == 8'h00 && !override_hit
        |=> sts_view == $past(sts_view) || $rose(btn_flag_q) || $rose(alarm_flag_q)
            || $rose(wake_flag_q))
        else $error("zero write changed a flag");
    a_override_off: assert property (override_hit |=> !pwr_on_q && state_q == ST_OFF
        ##1 !power_on_oe_o)
        else $error("override did not force off");
    a_override_flags: assert property (override_hit |=> ovr_flag_q && !btn_flag_q)
        else $error("override flags wrong");
    a_alarm_sets: assert property (alarm_i |=> alarm_flag_q)
        else $error("alarm did not set flag");
    a_sci_alarm: assert property (alarm_event_enable_i && alarm_i
        |=> ##1 sci_o)
        else $error("alarm SCI missing");
    a_mem_wake: assert property (mem_fire && !override_hit |=> pwr_on_q)
        else $error("remembered alarm did not power on");
    a_wake_edge: assert property (asleep && $rose(pwr_on_q)
        |=> wake_flag_q && state_q == ST_WORK)
        else $error("wake edge not recorded");
    a_wake_clear: assert property (wake_flag_q && !pwr_on_q && !wake_set
        |=> wake_flag_q)
        else $error("wake flag cleared while off");
    a_read_zero: assert property (rd_hit |=> io_rdata_o[6:4] == 3'b000
        && !io_rdata_o[1])
        else $error("reserved bits read nonzero");
    a_override_gate: assert property (!override_enable_i |=> !$rose(ovr_flag_q))
        else $error("override without enable");

    c_override: cover property (override_hit ##1 ovr_flag_q);
    c_wake: cover property (asleep && btn_rise ##[1:4] state_q == ST_WORK);
    c_mem: cover property (mem_fire);
    c_clear: cover property (wr_hit && io_wdata_i[BIT_WAKE] && pwr_on_q ##1 !wake_flag_q);

endmodule : apsts_status_hi

// ---- rtl/apsts_sync3.sv ----
// Three-stage input synchroniser with agreement filter.
// Assumes inputs are asynchronous to mclk_i.
`timescale 1ns/1ps
module apsts_sync3 #(
    parameter int WIDTH = 1
) (
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] level_o
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= async_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Output follows only once the last two stages agree
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            level_o <= '0;
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    level_o[i] <= s3_q[i];
                end
            end
        end
    end
endmodule : apsts_sync3

// ---- verification/apsts_host_model.sv ----
// Host software model: byte reads and writes on the system I/O strobes.
// Assumes the bench calls its tasks 1 ns after mclk_i rises.
`timescale 1ns/1ps
module apsts_host_model (
    input wire logic mclk_i,
    output logic [apsts_pkg::IO_ADDR_W-1:0] io_addr_o,
    output logic io_wr_o,
    output logic io_rd_o,
    output logic [7:0] io_wdata_o,
    input wire logic [7:0] io_rdata_i
);
    import apsts_pkg::*;

    initial begin
        io_addr_o = '0;
        io_wr_o = 1'b0;
        io_rd_o = 1'b0;
        io_wdata_o = 8'h00;
    end

    // Released lines flip, so a stale value is never mistaken for a hold
    task automatic release_bus();
        io_addr_o = ~io_addr_o;
        io_wdata_o = ~io_wdata_o;
    endtask : release_bus

    task automatic wr(input logic [IO_ADDR_W-1:0] a, input logic [7:0] d);
        io_addr_o = a;
        io_wdata_o = d & STS_HI_RD_MASK;
        io_wr_o = 1'b1;
        @(posedge mclk_i);
        #1;
        io_wr_o = 1'b0;
        release_bus();
        // Idle edge, so a next call never re-raises a strobe in this step
        @(posedge mclk_i);
        #1;
    endtask : wr

    task automatic rd(input logic [IO_ADDR_W-1:0] a, output logic [7:0] d);
        io_addr_o = a;
        io_rd_o = 1'b1;
        @(posedge mclk_i);
        #1;
        io_rd_o = 1'b0;
        d = io_rdata_i;
        release_bus();
        @(posedge mclk_i);
        #1;
    endtask : rd
endmodule : apsts_host_model

// ---- verification/tb_acpi_pm1_status_two.sv ----
// Self-checking bench for the second power-management status register.
// Assumes shortened hold timing: divider 2, hold count 4.
`timescale 1ns/1ps
module tb_acpi_pm1_status_two;
    import apsts_pkg::*;

    localparam logic [11:0] BASE = 12'h3A0;
    localparam logic [11:0] STS = BASE + STS_HI_OFFSET;

    logic mclk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [11:0] io_addr;
    logic io_wr, io_rd;
    logic [7:0] io_wdata, io_rdata, rd_v;
    logic button = 1'b0, standby = 1'b1, alarm = 1'b0, wake_ev = 1'b0, sleep_req = 1'b0;
    logic btn_en = 1'b0, alm_en = 1'b0, ovr_en = 1'b0, mem_en = 1'b0, wsel = 1'b0;
    logic sci, wake_pulse, pwr_n, pwr_oe, working;
    int n_fail = 0;
    int cmp_count = 0;
    int cycles = 0;

    initial begin
        forever #5 mclk_i = ~mclk_i;
    end

    apsts_status_hi #(.STBY_DIV_P(2), .HOLD_TICKS_P(4)) dut_u (
        .mclk_i(mclk_i), .reset_i(reset_i), .pm_block_base_i(BASE),
        .io_addr_i(io_addr), .io_wr_i(io_wr), .io_rd_i(io_rd),
        .io_wdata_i(io_wdata), .io_rdata_o(io_rdata),
        .button_in_i(button), .standby_present_i(standby), .alarm_i(alarm),
        .wake_event_i(wake_ev), .sleep_req_i(sleep_req),
        .button_event_enable_i(btn_en), .alarm_event_enable_i(alm_en),
        .override_enable_i(ovr_en), .alarm_memory_enable_i(mem_en),
        .wake_source_select_i(wsel), .sci_o(sci), .wake_pulse_o(wake_pulse),
        .power_on_out_n_o(pwr_n), .power_on_oe_o(pwr_oe), .working_o(working)
    );

    apsts_host_model host_u (
        .mclk_i(mclk_i), .io_addr_o(io_addr), .io_wr_o(io_wr), .io_rd_o(io_rd),
        .io_wdata_o(io_wdata), .io_rdata_i(io_rdata)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic final_report();
        if (n_fail == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask : tick

    // Pin stays up long enough to pass the synchroniser filter
    task automatic press(input int n);
        button = 1'b1;
        tick(n);
        button = 1'b0;
        tick(12);
    endtask : press

    task automatic pulse_sleep();
        sleep_req = 1'b1;
        tick(1);
        sleep_req = 1'b0;
        tick(4);
    endtask : pulse_sleep

    // Cut a hang short; no test should come near this count
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            final_report();
        end
    end

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        tick(12);
        reset_i = 1'b0;
        tick(1);
        host_u.rd(STS, rd_v);
        check(rd_v, STS_HI_RESET);
        check(pwr_oe, 1'b0);
        press(8);
        check(pwr_oe, 1'b1);
        check(working, 1'b1);
        check(pwr_n, 1'b0);
        host_u.rd(STS, rd_v);
        check(rd_v, 8'h81);
        host_u.wr(STS, 8'h00);
        host_u.wr(BASE, 8'h81);
        host_u.rd(STS, rd_v);
        check(rd_v, 8'h81);
        host_u.rd(BASE + 12'h002, rd_v);
        check(rd_v, 8'h00);
        // Held press with override enabled forces soft off
        ovr_en = 1'b1;
        press(60);
        check(pwr_oe, 1'b0);
        check(working, 1'b0);
        host_u.rd(STS, rd_v);
        check(rd_v, 8'h88);
        host_u.wr(STS, 8'h80);
        host_u.rd(STS, rd_v);
        check(rd_v, 8'h88);
        host_u.wr(STS, 8'h08);
        host_u.rd(STS, rd_v);
        check(rd_v, 8'h80);
        ovr_en = 1'b0;
        press(8);
        check(pwr_oe, 1'b1);
        // Two short holds must not add up to an override
        ovr_en = 1'b1;
        press(8);
        press(8);
        check(pwr_oe, 1'b1);
        ovr_en = 1'b0;
        btn_en = 1'b1;
        tick(2);
        check(sci, 1'b1);
        host_u.wr(STS, 8'h01);
        host_u.rd(STS, rd_v);
        check(rd_v, 8'h80);
        tick(1);
        check(sci, 1'b0);
        host_u.wr(STS, 8'h80);
        host_u.rd(STS, rd_v);
        check(rd_v, 8'h00);
        // Alarm with its enable
        alm_en = 1'b1;
        alarm = 1'b1;
        tick(1);
        alarm = 1'b0;
        tick(2);
        check(sci, 1'b1);
        host_u.rd(STS, rd_v);
        check(rd_v, 8'h04);
        host_u.wr(STS, 8'h04);
        tick(2);
        check(sci, 1'b0);
        // Long hold without override enable keeps power on and sets only the button flag
        press(60);
        check(pwr_oe, 1'b1);
        host_u.rd(STS, rd_v);
        check(rd_v, 8'h01);
        host_u.wr(STS, 8'h01);
        // Extra wake source while asleep
        wsel = 1'b1;
        pulse_sleep();
        check(pwr_oe, 1'b0);
        check(working, 1'b0);
        wake_ev = 1'b1;
        tick(1);
        wake_ev = 1'b0;
        check(wake_pulse, 1'b1);
        tick(1);
        // Selected source wakes a cycle before the power-on edge would
        check(working, 1'b1);
        tick(7);
        check(working, 1'b1);
        host_u.rd(STS, rd_v);
        check(rd_v, 8'h80);
        // Alarm remembered while standby supply is gone
        wsel = 1'b0;
        pulse_sleep();
        standby = 1'b0;
        mem_en = 1'b1;
        tick(6);
        alarm = 1'b1;
        tick(1);
        alarm = 1'b0;
        tick(4);
        check(pwr_oe, 1'b0);
        standby = 1'b1;
        tick(12);
        check(pwr_oe, 1'b1);
        host_u.rd(STS, rd_v);
        check(rd_v, 8'h84);
        final_report();
    end
endmodule : tb_acpi_pm1_status_two
